// ### rtl/tdrc_consts.svh
/*
 * Register offsets, field positions, reset values and codes of the dual channel timer run control.
 * Assumes inclusion by bare name from the design files; it holds definitions only.
 */
`ifndef TDRC_CONSTS_SVH
`define TDRC_CONSTS_SVH

// ********************************************************
// Register map, offsets within a unit
// ********************************************************
`define TDRC_OFF_RUN 6'h00
`define TDRC_OFF_MODE 6'h04
`define TDRC_OFF_FUNC 6'h08
`define TDRC_OFF_STAT 6'h0c
`define TDRC_OFF_CNT0 6'h30
`define TDRC_OFF_CNT1 6'h34
`define TDRC_GR0_SEL 2'h1
`define TDRC_GR1_SEL 2'h2
`define TDRC_UNIT_BIT 6

// ********************************************************
// Fields and reset values
// ********************************************************
`define TDRC_RUN_RSV 4'hf
`define TDRC_RUN_RESET 2'h0
`define TDRC_STOP_RESET 2'h3
`define TDRC_STOP_LSB 2
`define TDRC_SYNC_BIT 0
`define TDRC_FUNC_MODE_LSB 0
`define TDRC_FUNC_EXT_BIT 2
`define TDRC_FUNC_DIR_LSB 8
`define TDRC_FUNC_PWM_LSB 16
`define TDRC_GR_RESET 16'hffff

// ********************************************************
// Unit modes, pin letters, bus codes
// ********************************************************
`define TDRC_MODE_TIMER 2'h0
`define TDRC_MODE_PWM 2'h1
`define TDRC_MODE_RSYNC 2'h2
`define TDRC_MODE_CPWM 2'h3
`define TDRC_PIN_A 0
`define TDRC_PIN_C 2
`define TDRC_HSIZE_WORD 3'h2

`endif

// ### rtl/tdrc_pkg.sv
/*
 * Types shared by the timer run control files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tdrc_pkg;
    // Address phase held over into the data phase
    typedef struct packed {
        logic valid;
        logic write;
        logic unit;
        logic [5:0] off;
    } tdrc_bus_req_t;

    // Per channel pin levels: compare output level and PWM level
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] pwm;
    } tdrc_pin_lvl_t;
endpackage

// ### rtl/tdrc_channel.sv
/*
 * One timer channel: counter, four general registers, compare and capture per pin.
 * Assumes a common clock and a count tick enable; the owner gives run, writes and pin edges.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tdrc_consts.svh"

module tdrc_channel
    import tdrc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int NPIN = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Count control
    input wire logic run,
    input wire logic tick,
    input wire logic cnt_we,
    input wire logic [WIDTH-1:0] cnt_wdata,
    // General registers
    input wire logic gr_we,
    input wire logic [1:0] gr_sel,
    input wire logic [WIDTH-1:0] gr_wdata,
    input wire logic [1:0] rd_sel,
    // Pin side
    input wire logic [NPIN-1:0] dir_out,
    input wire logic [NPIN-1:0] pin_rise,
    // Results
    output logic [WIDTH-1:0] cnt,
    output logic [WIDTH-1:0] rd_gr,
    output logic [NPIN-1:0] match,
    output tdrc_pin_lvl_t lvl
);
    logic [WIDTH-1:0] gr [NPIN];
    logic [NPIN-1:0] out_lvl;
    logic [NPIN-1:0] pwm_lvl;

    assign lvl = {out_lvl, pwm_lvl};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (cnt_we) begin
            cnt <= cnt_wdata;
        end else if (run && tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    always_comb begin
        rd_gr = gr[rd_sel];
    end

    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        // Match is taken on the counting edge only
        assign match[i] = run && tick && (cnt == gr[i]);
        assign pwm_lvl[i] = (cnt < gr[i]);

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                gr[i] <= `TDRC_GR_RESET;
            end else if (gr_we && gr_sel == 2'(i)) begin
                gr[i] <= gr_wdata;
            end else if (!dir_out[i] && pin_rise[i]) begin
                gr[i] <= cnt;
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                out_lvl[i] <= 1'b0;
            end else if (dir_out[i] && match[i]) begin
                out_lvl[i] <= ~out_lvl[i];
            end
        end

        capture_load_a: assert property (@(posedge clk) disable iff (!rst_n)
            (!dir_out[i] && pin_rise[i] && !(gr_we && gr_sel == 2'(i))) |=> (gr[i] == $past(cnt)))
            else $error("capture did not load counter value");
    end

    count_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!run && !cnt_we) |=> $stable(cnt))
        else $error("counter moved while stopped");
endmodule
`default_nettype wire

// ### rtl/tdrc_top.sv
/*
 * Two timer units of two channels each: run control, pin arrangement, AHB-Lite register slave.
 * Assumes a single 20 MHz clock, synchronous pin and event inputs, and one AHB-Lite master.
 */
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tdrc_consts.svh"

module tdrc_top
    import tdrc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int CLK_DIV = 1
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Timer pins, eight per unit
    input wire logic [15:0] PIN_IN,
    output logic [15:0] PIN_OUT,
    output logic [15:0] PIN_OE,
    // Unit output disable inputs
    input wire logic [1:0] OUTPUT_DISABLE_IN,
    // Event link, one bit per unit
    input wire logic [1:0] EVENT_A,
    input wire logic [1:0] EVENT_B,
    input wire logic [1:0] EVL_OP_A_CNT,
    input wire logic [1:0] EVL_OP_B_CNT
);
    // ********************************************************
    // Control state
    // ********************************************************
    tdrc_bus_req_t ap;
    logic [3:0] run_bit;
    logic [3:0] stop_bit;
    logic [1:0] sync;
    logic [1:0] umode [2];
    logic [1:0] ext_clk;
    logic [15:0] dir;
    logic [15:0] pwm_en;
    logic [15:0] pin_q;
    logic [7:0] div_cnt;
    logic int_tick;
    logic rd_is_run;

    logic taken;
    logic wr;
    logic rd_pend;
    logic [1:0] wr_run;
    logic [1:0] wr_mode;
    logic [1:0] wr_func;
    logic [3:0] gr_we;
    logic [3:0] cnt_we;
    logic [3:0] ev;
    logic [3:0] run_set;
    logic [3:0] run_clr;
    logic [1:0] tick;
    logic [15:0] pin_rise;
    logic [15:0] next_pin_out;
    logic [15:0] next_pin_oe;
    logic [31:0] next_rdata;
    logic [WIDTH-1:0] cnt_w [4];
    logic [WIDTH-1:0] rd_gr_w [4];
    logic [3:0] match_w [4];
    tdrc_pin_lvl_t lvl_w [4];

    // ********************************************************
    // Bus slave
    // ********************************************************
    assign taken = HSEL && HREADY && HTRANS[1];
    assign wr = ap.valid && ap.write;
    assign rd_pend = ap.valid && !ap.write && !HREADYOUT;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ap <= '0;
        end else if (HREADY) begin
            ap.valid <= taken && (HSIZE == `TDRC_HSIZE_WORD);
            ap.write <= HWRITE;
            ap.unit <= HADDR[`TDRC_UNIT_BIT];
            ap.off <= HADDR[5:0];
        end
    end

    // Reads take one wait state so that a write just before is seen
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            HREADYOUT <= 1'b1;
        end else if (taken && !HWRITE) begin
            HREADYOUT <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            HRDATA <= '0;
            rd_is_run <= 1'b0;
        end else if (rd_pend) begin
            HRDATA <= next_rdata;
            rd_is_run <= (ap.off == `TDRC_OFF_RUN);
        end
    end

    always_comb begin
        next_rdata = '0;
        case (ap.off)
            `TDRC_OFF_RUN: next_rdata = 32'({`TDRC_RUN_RSV, stop_bit[ap.unit*2 +: 2], run_bit[ap.unit*2 +: 2]});
            `TDRC_OFF_MODE: next_rdata = 32'(sync[ap.unit]);
            `TDRC_OFF_FUNC: next_rdata = 32'({pwm_en[ap.unit*8 +: 8], dir[ap.unit*8 +: 8], 5'h0,
                                              ext_clk[ap.unit], umode[ap.unit]});
            `TDRC_OFF_STAT: next_rdata = 32'({OUTPUT_DISABLE_IN[ap.unit], PIN_IN[ap.unit*8 +: 8]});
            `TDRC_OFF_CNT0: next_rdata = 32'(cnt_w[ap.unit*2]);
            `TDRC_OFF_CNT1: next_rdata = 32'(cnt_w[ap.unit*2+1]);
            default: begin
                if (ap.off[5:4] == `TDRC_GR0_SEL) begin
                    next_rdata = 32'(rd_gr_w[ap.unit*2]);
                end else if (ap.off[5:4] == `TDRC_GR1_SEL) begin
                    next_rdata = 32'(rd_gr_w[ap.unit*2+1]);
                end
            end
        endcase
    end

    // ********************************************************
    // Write decode
    // ********************************************************
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            wr_run[u] = wr && (ap.unit == 1'(u)) && (ap.off == `TDRC_OFF_RUN);
            wr_mode[u] = wr && (ap.unit == 1'(u)) && (ap.off == `TDRC_OFF_MODE);
            wr_func[u] = wr && (ap.unit == 1'(u)) && (ap.off == `TDRC_OFF_FUNC);
        end
        for (int ch = 0; ch < 4; ch++) begin
            gr_we[ch] = wr && (ap.unit == 1'(ch / 2))
                        && (ap.off[5:4] == ((ch % 2 == 0) ? `TDRC_GR0_SEL : `TDRC_GR1_SEL));
            // A counter write presets both counters of a synchronous unit
            cnt_we[ch] = wr && (ap.unit == 1'(ch / 2))
                         && ((ap.off == ((ch % 2 == 0) ? `TDRC_OFF_CNT0 : `TDRC_OFF_CNT1))
                         || (sync[ch / 2] && (ap.off == `TDRC_OFF_CNT0 || ap.off == `TDRC_OFF_CNT1)));
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sync <= '0;
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (wr_mode[u]) begin
                    sync[u] <= HWDATA[`TDRC_SYNC_BIT];
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            umode[0] <= `TDRC_MODE_TIMER;
            umode[1] <= `TDRC_MODE_TIMER;
            ext_clk <= '0;
            dir <= '0;
            pwm_en <= '0;
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (wr_func[u]) begin
                    umode[u] <= HWDATA[`TDRC_FUNC_MODE_LSB +: 2];
                    ext_clk[u] <= HWDATA[`TDRC_FUNC_EXT_BIT];
                    dir[u*8 +: 8] <= HWDATA[`TDRC_FUNC_DIR_LSB +: 8];
                    pwm_en[u*8 +: 8] <= HWDATA[`TDRC_FUNC_PWM_LSB +: 8];
                end
            end
        end
    end

    // ********************************************************
    // Count clock sources
    // ********************************************************
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            div_cnt <= '0;
            int_tick <= 1'b0;
        end else if (div_cnt == 8'(CLK_DIV - 1)) begin
            div_cnt <= '0;
            int_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            int_tick <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            pin_q <= '0;
        end else begin
            pin_q <= PIN_IN;
        end
    end

    assign pin_rise = PIN_IN & ~pin_q;

    for (genvar u = 0; u < 2; u++) begin : g_tick
        // Channel 0 pin A edges count when the external clock is chosen
        assign tick[u] = ext_clk[u] ? pin_rise[u*8 + `TDRC_PIN_A] : int_tick;
    end

    // ********************************************************
    // Channels and run control
    // ********************************************************
    for (genvar ch = 0; ch < 4; ch++) begin : g_ch
        localparam int U = ch / 2;
        localparam int C = ch % 2;

        tdrc_channel #(
            .WIDTH(WIDTH),
            .NPIN(4)
        ) u_channel (
            .clk(CLK_SYS),
            .rst_n(RST_N),
            .run(run_bit[ch]),
            .tick(tick[U]),
            .cnt_we(cnt_we[ch]),
            .cnt_wdata(HWDATA[WIDTH-1:0]),
            .gr_we(gr_we[ch]),
            .gr_sel(ap.off[3:2]),
            .gr_wdata(HWDATA[WIDTH-1:0]),
            .rd_sel(ap.off[3:2]),
            .dir_out(dir[ch*4 +: 4]),
            .pin_rise(pin_rise[ch*4 +: 4]),
            .cnt(cnt_w[ch]),
            .rd_gr(rd_gr_w[ch]),
            .match(match_w[ch]),
            .lvl(lvl_w[ch])
        );

        assign ev[ch] = (C == 0) ? (EVENT_A[U] && EVL_OP_A_CNT[U]) : (EVENT_B[U] && EVL_OP_B_CNT[U]);
        assign run_set[ch] = (wr_run[U] && HWDATA[C]) || ev[ch];
        assign run_clr[ch] = (wr_run[U] && !HWDATA[C] && stop_bit[ch])
                             || (match_w[ch][`TDRC_PIN_A] && !stop_bit[ch]);

        // A setting event wins over a clear in the same cycle
        always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
                run_bit[ch] <= 1'(`TDRC_RUN_RESET >> C);
            end else if (run_set[ch]) begin
                run_bit[ch] <= 1'b1;
            end else if (run_clr[ch]) begin
                run_bit[ch] <= 1'b0;
            end
        end

        // Whole-register writes only; software must also write the reserved ones
        always_ff @(posedge CLK_SYS) begin
            if (!RST_N) begin
                stop_bit[ch] <= 1'(`TDRC_STOP_RESET >> C);
            end else if (wr_run[U]) begin
                stop_bit[ch] <= HWDATA[`TDRC_STOP_LSB + C];
            end
        end

        sequence match_stop_s;
            match_w[ch][`TDRC_PIN_A] && !stop_bit[ch] && !run_set[ch];
        endsequence

        sequence zero_write_s;
            wr_run[U] && !HWDATA[C];
        endsequence

        run_write_one_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
            (wr_run[U] && HWDATA[C]) |=> run_bit[ch])
            else $error("written one did not start channel");
        match_stop_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
            match_stop_s |=> (!run_bit[ch] ##1 (run_bit[ch] == $past(run_set[ch]))))
            else $error("match did not stop channel");
        zero_ignored_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
            (zero_write_s ##0 (!stop_bit[ch] && !match_w[ch][`TDRC_PIN_A] && !ev[ch]))
            |=> (run_bit[ch] == $past(run_bit[ch])))
            else $error("written zero cleared run while stop bit was zero");
        event_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
            ev[ch] |=> run_bit[ch])
            else $error("event did not start channel");
    end

    // ********************************************************
    // Pin arrangement
    // ********************************************************
    for (genvar p = 0; p < 16; p++) begin : g_pin
        localparam int U = p / 8;
        localparam int C = (p / 4) % 2;
        localparam int K = p % 4;
        localparam int CH = p / 4;
        logic combined;
        logic special;

        assign combined = (umode[U] == `TDRC_MODE_RSYNC) || (umode[U] == `TDRC_MODE_CPWM);
        assign special = (C == 0 && K == `TDRC_PIN_C) || (C == 1 && K == `TDRC_PIN_A);

        always_comb begin
            next_pin_out[p] = lvl_w[CH].lvl[K];
            next_pin_oe[p] = dir[p];
            if (combined && special) begin
                next_pin_out[p] = lvl_w[CH].pwm[`TDRC_PIN_A];
                next_pin_oe[p] = 1'b1;
            end else if ((combined || umode[U] == `TDRC_MODE_PWM) && pwm_en[p] && K != `TDRC_PIN_A) begin
                next_pin_out[p] = lvl_w[CH].pwm[K];
            end
            if (ext_clk[U] && C == 0 && K == `TDRC_PIN_A) begin
                next_pin_oe[p] = 1'b0;
            end
            if (OUTPUT_DISABLE_IN[U]) begin
                next_pin_oe[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            PIN_OUT <= '0;
            PIN_OE <= '0;
        end else begin
            PIN_OUT <= next_pin_out;
            PIN_OE <= next_pin_oe;
        end
    end

    // ********************************************************
    // Checks across the unit
    // ********************************************************
    reserved_ones_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (rd_pend && ap.off == `TDRC_OFF_RUN) |=> (HREADYOUT && rd_is_run && HRDATA[7:4] == `TDRC_RUN_RSV))
        else $error("reserved run bits not read as one");
    disable_pins_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        OUTPUT_DISABLE_IN[0] |=> (PIN_OE[7:0] == 8'h00))
        else $error("unit 0 outputs driven while disabled");
    ext_clock_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        ext_clk[1] |=> !PIN_OE[8 + `TDRC_PIN_A])
        else $error("external clock pin driven");
    reset_state_a: assert property (@(posedge CLK_SYS)
        !RST_N |=> (run_bit == 4'h0 && stop_bit == 4'hf))
        else $error("run control reset values wrong");
    sync_preset_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (wr && sync[0] && !ap.unit && ap.off == `TDRC_OFF_CNT1) |=> (cnt_w[0] == cnt_w[1]))
        else $error("synchronous preset missed a counter");
    read_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (taken && !HWRITE) |=> (!HREADYOUT ##1 HREADYOUT))
        else $error("read answer not after one wait state");
endmodule
`default_nettype wire

// ### tb/tdrc_pin_model.sv
/*
 * Far side of the timer pins: an external level per pin.
 * Assumes the design's pin levels and output enables.
 */
`timescale 1ns/100ps
`default_nettype none

module tdrc_pin_model (
    // Design side
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    // Stimulus side
    input wire logic [15:0] ext_lvl,
    output logic [15:0] pin_lvl
);
    // Driven pins carry the design level, released pins the outside one
    assign pin_lvl = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule

`default_nettype wire

// ### tb/dual_channel_timer_run_control_tb.sv
/*
 * Self-checking bench of the timer run control over AHB-Lite.
 * Assumes the design answers writes at once and reads after one wait.
 */
`timescale 1ns/100ps
`default_nettype none

module dual_channel_timer_run_control_tb;
    logic clk_sys;
    logic rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c1;
    logic [1:0] htrans = 2'h0, odis = 2'h0, ev_a = 2'h0, ev_b = 2'h0, op_a = 2'h0, op_b = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp;
    logic [15:0] pin_out, pin_oe, pin_in, ext_lvl = 16'h0;
    int n_fail = 0, check_count = 0;

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    tdrc_top dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .OUTPUT_DISABLE_IN(odis), .EVENT_A(ev_a), .EVENT_B(ev_b), .EVL_OP_A_CNT(op_a),
        .EVL_OP_B_CNT(op_b));

    tdrc_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_lvl(pin_in));

    // ********************
    // Bus and check tasks
    // ********************
    task end_sim;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            end_sim;
        end
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rv);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rv = hrdata;
        chk({31'h0, hresp}, 32'h0, "response");
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask

    task rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0, rd);
        chk(rd, exp, what);
    endtask

    // ********************
    // Scenarios
    // ********************
    task t_reset;
        rdc(32'h00, 32'hfc, "unit 0 run reset");
        rdc(32'h40, 32'hfc, "unit 1 run reset");
        rdc(32'h3c, 32'h0, "unmapped read");
        $display("reset test done");
    endtask

    task t_sw_run;
        wr(32'h30, 32'h0);
        wr(32'h00, 32'hfd);
        rdc(32'h00, 32'hfd, "run set");
        bus(1'b0, 32'h30, 32'h0, c1);
        bus(1'b0, 32'h30, 32'h0, rd);
        chk({31'h0, rd[15:0] > c1[15:0]}, 32'h1, "counting");
        wr(32'h00, 32'hfc);
        rdc(32'h00, 32'hfc, "zero clears");
        bus(1'b0, 32'h30, 32'h0, c1);
        rdc(32'h30, c1, "stopped");
        $display("software run test done");
    endtask

    task t_match;
        for (int ch = 0; ch < 2; ch++) begin
            wr(32'h10 + 32'h10 * ch, 32'h8);
            wr(32'h30 + 32'h4 * ch, 32'h0);
            wr(32'h00, 32'hf0 | (32'h1 << ch));
            repeat (20) @(posedge clk_sys);
            rdc(32'h00, 32'hf0, "match stop");
            bus(1'b0, 32'h30 + 32'h4 * ch, 32'h0, c1);
            rdc(32'h30 + 32'h4 * ch, c1, "held");
            wr(32'h00, 32'hfc | (32'h1 << ch));
            rdc(32'h00, 32'hfc | (32'h1 << ch), "restart");
            wr(32'h00, 32'hfc);
        end
        wr(32'h20, 32'hffff);
        wr(32'h34, 32'h0);
        wr(32'h00, 32'hf2);
        wr(32'h00, 32'hf0);
        rdc(32'h00, 32'hf2, "zero ignored");
        wr(32'h00, 32'hfa);
        wr(32'h00, 32'hf8);
        rdc(32'h00, 32'hf8, "zero clears");
        wr(32'h00, 32'hfc);
        $display("match test done");
    endtask

    task t_event;
        @(posedge clk_sys);
        op_a <= 2'h1;
        op_b <= 2'h2;
        @(posedge clk_sys);
        ev_a <= 2'h1;
        ev_b <= 2'h3;
        @(posedge clk_sys);
        ev_a <= 2'h0;
        ev_b <= 2'h0;
        rdc(32'h00, 32'hfd, "event unit 0");
        rdc(32'h40, 32'hfe, "event unit 1");
        wr(32'h00, 32'hfc);
        wr(32'h40, 32'hfc);
        $display("event test done");
    endtask

    task t_disable;
        wr(32'h08, 32'h0000ff00);
        repeat (2) @(posedge clk_sys);
        chk({24'h0, pin_oe[7:0]}, 32'hff, "outputs on");
        odis <= 2'h1;
        repeat (2) @(posedge clk_sys);
        chk({24'h0, pin_oe[7:0]}, 32'h0, "outputs off");
        rdc(32'h0c, 32'h100, "status");
        odis <= 2'h0;
        $display("disable test done");
    endtask

    task t_pins;
        wr(32'h08, 32'h1402);
        wr(32'h30, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'h1414, "sync pwm pins high");
        wr(32'h30, 32'h10);
        repeat (2) @(posedge clk_sys);
        chk({16'h0, pin_oe[7:0], pin_out[7:0]}, 32'h1410, "sync pwm pin low");
        wr(32'h08, 32'h0);
        wr(32'h04, 32'h1);
        wr(32'h34, 32'h55);
        rdc(32'h30, 32'h55, "sync preset");
        wr(32'h04, 32'h0);
        $display("pin and sync test done");
    endtask

    task t_ext;
        wr(32'h48, 32'h104);
        wr(32'h70, 32'h0);
        wr(32'h40, 32'hfd);
        repeat (3) begin
            @(posedge clk_sys);
            ext_lvl <= 16'h0300;
            @(posedge clk_sys);
            ext_lvl <= 16'h0;
        end
        repeat (2) @(posedge clk_sys);
        chk({31'h0, pin_oe[8]}, 32'h0, "clock pin released");
        rdc(32'h70, 32'h3, "external count");
        rdc(32'h54, 32'h2, "capture");
        wr(32'h40, 32'hfc);
        wr(32'h48, 32'h0);
        $display("external clock test done");
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_sw_run;
        t_match;
        t_event;
        t_disable;
        t_pins;
        t_ext;
        end_sim;
    end
endmodule

`default_nettype wire
